// File: logic/ecs_error_unit.sv
// Error consumption, containment, reporting and failure mode logic.
// Assumes all inputs are synchronous to mclk and driven by on-chip logic;
// the register port never stalls and answers reads one cycle later.
`timescale 1ns/1ps
module ecs_error_unit (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  input  wire ecs_pkg::ecs_sec_t    regSec,
  output logic      [31:0]          regRdData,
  input  wire ecs_pkg::ecs_txn_t    txnIn,
  output ecs_pkg::ecs_resp_t        respOut,
  input  wire ecs_pkg::ecs_qerr_t   qErrIn,
  input  wire ecs_pkg::ecs_interr_t intErrIn,
  output ecs_pkg::ecs_evt_t         evtOut,
  output logic                      queueEnable,
  output logic                      errRecoveryReq,
  output logic                      failureModeIrq,
  input  wire ecs_pkg::ecs_dbg_t    dbgIn,
  output logic                      dbgGrant,
  output logic                      dbgDeny
);
  logic        rstMeta;
  logic        rstSync;
  logic [3:0]  ctrl;
  logic        service_failure_mode;
  logic [1:0]  syndrome;
  logic        isoSeen;
  logic [31:0] gerr [3];
  logic [6:0]  consErr [3];
  logic [3:0]  dptFar;
  logic        sfmEnter;
  logic        txnErr;
  logic        qErr;
  logic        consumed;
  logic [31:0] next_rdData;

  // Bank of a security state; Root faults land in the Secure bank
  function automatic logic [1:0] bankOf(input ecs_pkg::ecs_sec_t s);
    case (s)
      ecs_pkg::SEC_NS: bankOf = 2'h0;
      ecs_pkg::SEC_R:  bankOf = 2'h2;
      default:         bankOf = 2'h1;
    endcase
  endfunction

  // Security isolation check shared by registers, debug and cache readout
  function automatic logic canAccess(input ecs_pkg::ecs_sec_t agent,
                                     input ecs_pkg::ecs_sec_t target,
                                     input logic [3:0] c);
    logic ok;
    ok = 1'b0;
    case (target)
      ecs_pkg::SEC_NS:
        ok = 1'b1;
      ecs_pkg::SEC_S:
        ok = c[ecs_pkg::CTRL_SEC] &&
             (agent == ecs_pkg::SEC_S || agent == ecs_pkg::SEC_ROOT);
      ecs_pkg::SEC_R:
        ok = c[ecs_pkg::CTRL_REALM] &&
             (agent == ecs_pkg::SEC_R || agent == ecs_pkg::SEC_ROOT);
      ecs_pkg::SEC_ROOT:
        ok = c[ecs_pkg::CTRL_ROOT] && agent == ecs_pkg::SEC_ROOT;
      default:
        ok = 1'b0;
    endcase
    canAccess = ok;
  endfunction

  // Reset release through two flops so removal is glitch free
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Error classification for this cycle
  always_comb
  begin
    txnErr   = txnIn.valid && txnIn.err != ecs_pkg::ERR_NONE;
    // queue traffic is dead once failed
    qErr     = qErrIn.valid && !service_failure_mode;
    consumed = txnErr || qErr || intErrIn.valid;
    sfmEnter = !service_failure_mode && ((intErrIn.valid && !intErrIn.isolated) ||
               (txnIn.valid && txnIn.err == ecs_pkg::ERR_REGUE));
  end

  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      service_failure_mode <= 1'b0;
    else if (sfmEnter)
      service_failure_mode <= 1'b1;
  end

  // Cause of entry kept for diagnosis; isolated hits noted separately
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      syndrome <= 2'h0;
      isoSeen  <= 1'b0;
    end
    else
    begin
      if (sfmEnter)
        syndrome <= (intErrIn.valid && !intErrIn.isolated) ? 2'h1 : 2'h2;
      if (intErrIn.valid && intErrIn.isolated)
        isoSeen <= 1'b1;
      else if (regWr && regAddr == ecs_pkg::OFF_STATUS &&
               regWrData[ecs_pkg::ST_ISO])
        isoSeen <= 1'b0;
    end
  end

  // Implementation controls; only a Root agent may change them
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      ctrl <= ecs_pkg::CTRL_RST;
    else if (regWr && regAddr == ecs_pkg::OFF_CTRL && regSec == ecs_pkg::SEC_ROOT)
      ctrl <= regWrData[3:0];
  end

  // Global error flags per bank, write one to clear; a set in the
  // same cycle as a clear wins so no event is lost
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      for (int b = 0; b < 3; b++)
        gerr[b] <= 32'h0;
    end
    else
    begin
      for (int b = 0; b < 3; b++)
      begin
        logic [31:0] set;
        logic [31:0] clr;
        logic [7:0]  off;
        set = 32'h0;
        off = (b == 0) ? ecs_pkg::OFF_GERR_NS :
              (b == 1) ? ecs_pkg::OFF_GERR_S : ecs_pkg::OFF_GERR_R;
        clr = (regWr && regAddr == off &&
               canAccess(regSec, ecs_pkg::ecs_sec_t'(b[1:0]), ctrl)) ?
              regWrData : 32'h0;
        if (qErr && bankOf(qErrIn.sec) == b[1:0])
        begin
          case (qErrIn.kind)
            ecs_pkg::Q_CMD:  set[ecs_pkg::GE_CMDQ] = 1'b1;
            ecs_pkg::Q_PRIQ: set[ecs_pkg::GE_PRIQ_ABT] = 1'b1;
            ecs_pkg::Q_EVTQ: set[ecs_pkg::GE_EVTQ_ABT] = 1'b1;
            ecs_pkg::Q_DPT:  set[ecs_pkg::GE_DPT] = 1'b1;
            default:         set = 32'h0;
          endcase
        end
        if (sfmEnter && (b == 0 || (b == 1 && ctrl[ecs_pkg::CTRL_SEC])))
          set[ecs_pkg::GE_SFM] = 1'b1;
        gerr[b] <= (gerr[b] & ~clr) | set;
      end
    end
  end

  // Consumer error field and permission table fault code
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      for (int b = 0; b < 3; b++)
        consErr[b] <= 7'h0;
      dptFar <= 4'h0;
    end
    else if (qErr)
    begin
      if (qErrIn.kind == ecs_pkg::Q_CMD)
        consErr[bankOf(qErrIn.sec)] <= ecs_pkg::CMD_ABORT_CODE;
      if (qErrIn.kind == ecs_pkg::Q_DPT)
        dptFar <= ecs_pkg::PERMISSION_TABLE_ABORT_CODE_CODE;
    end
  end

  // Client responses; an errored or post-failure transaction never passes
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      respOut <= '0;
    else
    begin
      respOut.valid <= txnIn.valid;
      respOut.abort <= txnIn.valid && (txnErr || service_failure_mode || sfmEnter);
      respOut.ca    <= txnIn.valid && txnIn.pcie && (txnErr || service_failure_mode || sfmEnter);
    end
  end

  // Fault event records; none are written once the queues are stopped
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      evtOut <= '0;
    else
    begin
      evtOut.valid <= txnErr && !service_failure_mode && !sfmEnter;
      evtOut.sec   <= txnIn.sec;
      case (txnIn.err)
        ecs_pkg::ERR_WALK: evtOut.code <= ecs_pkg::EVT_WALK_EABT;
        ecs_pkg::ERR_STE:  evtOut.code <= ecs_pkg::EVT_STE_FETCH;
        ecs_pkg::ERR_CD:   evtOut.code <= ecs_pkg::EVT_CD_FETCH;
        default:           evtOut.code <= ecs_pkg::EVT_INT_ABORT;
      endcase
    end
  end

  // Queue gate and recovery notifications
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      queueEnable    <= 1'b0;
      errRecoveryReq <= 1'b0;
      failureModeIrq <= 1'b0;
    end
    else
    begin
      queueEnable    <= !service_failure_mode && !sfmEnter;
      errRecoveryReq <= (consumed && ctrl[ecs_pkg::CTRL_RAS]) || sfmEnter;
      failureModeIrq <= service_failure_mode || sfmEnter;
    end
  end

  // Debug and cache readout gate; answer one cycle after the request
  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      dbgGrant <= 1'b0;
      dbgDeny  <= 1'b0;
    end
    else
    begin
      dbgGrant <= dbgIn.valid && canAccess(dbgIn.agent, dbgIn.target, ctrl);
      dbgDeny  <= dbgIn.valid && !canAccess(dbgIn.agent, dbgIn.target, ctrl);
    end
  end

  // Read mux; banks the agent may not see read as zero
  always_comb
  begin
    next_rdData = 32'h0;
    case (regAddr)
      ecs_pkg::OFF_CTRL:
        next_rdData = {28'h0, ctrl};
      ecs_pkg::OFF_STATUS:
        next_rdData = {28'h0, isoSeen, syndrome, service_failure_mode};
      ecs_pkg::OFF_GERR_NS:
        next_rdData = gerr[0];
      ecs_pkg::OFF_GERR_S:
        if (canAccess(regSec, ecs_pkg::SEC_S, ctrl))
          next_rdData = gerr[1];
      ecs_pkg::OFF_GERR_R:
        if (canAccess(regSec, ecs_pkg::SEC_R, ctrl))
          next_rdData = gerr[2];
      ecs_pkg::OFF_CONS_NS:
        next_rdData = {1'b0, consErr[0], 24'h0};
      ecs_pkg::OFF_CONS_S:
        if (canAccess(regSec, ecs_pkg::SEC_S, ctrl))
          next_rdData = {1'b0, consErr[1], 24'h0};
      ecs_pkg::OFF_CONS_R:
        if (canAccess(regSec, ecs_pkg::SEC_R, ctrl))
          next_rdData = {1'b0, consErr[2], 24'h0};
      ecs_pkg::OFF_DPT_FAR:
        next_rdData = {28'h0, dptFar};
      ecs_pkg::OFF_ROOTCR:
        next_rdData = {31'h0, ecs_pkg::ROOT_CONTROL_IMPLEMENTED_VAL};
      default:
        next_rdData = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
      regRdData <= 32'h0;
    else
      regRdData <= regRd ? next_rdData : 32'h0;
  end
endmodule

// File: logic/ecs_pkg.sv
// Shared constants and carrier types for the error containment unit.
// Assumes one clock domain; all event inputs come from logic on mclk.
package ecs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_GERR_NS = 8'h08;
  localparam logic [7:0] OFF_GERR_S  = 8'h0c;
  localparam logic [7:0] OFF_GERR_R  = 8'h10;
  localparam logic [7:0] OFF_CONS_NS = 8'h14;
  localparam logic [7:0] OFF_CONS_S  = 8'h18;
  localparam logic [7:0] OFF_CONS_R  = 8'h1c;
  localparam logic [7:0] OFF_DPT_FAR = 8'h20;
  localparam logic [7:0] OFF_ROOTCR  = 8'h24;
  // Control fields
  localparam int CTRL_SEC   = 0;
  localparam int CTRL_REALM = 1;
  localparam int CTRL_ROOT  = 2;
  localparam int CTRL_RAS   = 3;
  localparam logic [3:0] CTRL_RST = 4'hf;
  // Global error flag positions
  localparam int GE_CMDQ     = 0;
  localparam int GE_EVTQ_ABT = 2;
  localparam int GE_PRIQ_ABT = 3;
  localparam int GE_SFM      = 8;
  localparam int GE_DPT      = 9;
  // Status fields
  localparam int ST_SFM     = 0;
  localparam int ST_SYN_LSB = 1;
  localparam int ST_ISO     = 3;
  // Codes
  localparam int CONS_ERR_LSB = 24;
  localparam logic [6:0] CMD_ABORT_CODE  = 7'h02;
  localparam logic [3:0] PERMISSION_TABLE_ABORT_CODE_CODE   = 4'h1;
  localparam logic [7:0] EVT_WALK_EABT   = 8'h01;
  localparam logic [7:0] EVT_STE_FETCH   = 8'h02;
  localparam logic [7:0] EVT_CD_FETCH    = 8'h03;
  localparam logic [7:0] EVT_INT_ABORT   = 8'h04;
  localparam logic ROOT_CONTROL_IMPLEMENTED_VAL = 1'b1;

  typedef enum logic [1:0] {
    SEC_NS = 2'b00, SEC_S = 2'b01, SEC_R = 2'b10, SEC_ROOT = 2'b11
  } ecs_sec_t;
  typedef enum logic [2:0] {
    ERR_NONE = 3'b000, ERR_WALK = 3'b001, ERR_STE = 3'b010,
    ERR_CD = 3'b011, ERR_CACHE = 3'b100, ERR_REGUE = 3'b101
  } ecs_errkind_t;
  typedef enum logic [1:0] {
    Q_CMD = 2'b00, Q_PRIQ = 2'b01, Q_EVTQ = 2'b10, Q_DPT = 2'b11
  } ecs_qkind_t;
  typedef struct packed {
    logic valid; logic pcie; ecs_sec_t sec; ecs_errkind_t err;
  } ecs_txn_t;
  typedef struct packed { logic valid; logic abort; logic ca; } ecs_resp_t;
  typedef struct packed { logic valid; ecs_qkind_t kind; ecs_sec_t sec; } ecs_qerr_t;
  typedef struct packed { logic valid; logic isolated; } ecs_interr_t;
  typedef struct packed { logic valid; ecs_sec_t sec; logic [7:0] code; } ecs_evt_t;
  typedef struct packed {
    logic valid; logic cache; ecs_sec_t agent; ecs_sec_t target;
  } ecs_dbg_t;
endpackage

// File: test/ecs_checker.sv
// Port checker for the error containment unit.
// Assumes one clock, mclk, and the raw active-low reset rst_n.
`timescale 1ns/1ps
module ecs_checker (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire ecs_pkg::ecs_txn_t    txnIn,
  input wire ecs_pkg::ecs_resp_t   respOut,
  input wire ecs_pkg::ecs_interr_t intErrIn,
  input wire ecs_pkg::ecs_evt_t    evtOut,
  input wire logic                 queueEnable,
  input wire logic                 errRecoveryReq,
  input wire logic                 failureModeIrq,
  input wire ecs_pkg::ecs_dbg_t    dbgIn,
  input wire logic                 dbgGrant,
  input wire logic                 dbgDeny
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Entry cause while running, then the three visible signs of failure mode
  sequence s_cause;
    intErrIn.valid && !intErrIn.isolated && queueEnable;
  endsequence
  sequence s_failed;
    failureModeIrq && !queueEnable && errRecoveryReq;
  endsequence
  // Every transaction is answered exactly one cycle later
  a_resp_next: assert property (txnIn.valid |=> respOut.valid)
    else $error("transaction not answered");
  a_err_abort: assert property (txnIn.valid && txnIn.err != ecs_pkg::ERR_NONE |=> respOut.abort)
    else $error("consumed error not aborted");
  a_pcie_ca: assert property (respOut.valid |-> respOut.ca == (respOut.abort && $past(txnIn.pcie)))
    else $error("completer abort flag wrong");
  a_evt_bank: assert property (txnIn.valid && txnIn.err inside {ecs_pkg::ERR_WALK, ecs_pkg::ERR_STE,
    ecs_pkg::ERR_CD} && queueEnable && !intErrIn.valid |=> evtOut.valid && evtOut.sec == $past(txnIn.sec))
    else $error("event record missing or in wrong bank");
  a_sfm_entry: assert property (s_cause |=> s_failed)
    else $error("failure mode not entered");
  a_iso_calm: assert property (intErrIn.valid && intErrIn.isolated && !failureModeIrq &&
    !(txnIn.valid && txnIn.err == ecs_pkg::ERR_REGUE) |=> !failureModeIrq)
    else $error("isolated error entered failure mode");
  a_sfm_sticky: assert property (failureModeIrq |=> failureModeIrq)
    else $error("failure mode left without reset");
  a_sfm_quiet: assert property (failureModeIrq |-> !queueEnable)
    else $error("queues enabled in failure mode");
  a_sfm_abort: assert property (txnIn.valid && failureModeIrq |=> respOut.abort)
    else $error("transaction passed in failure mode");
  a_dbg_once: assert property (dbgIn.valid |=> dbgGrant != dbgDeny)
    else $error("debug request not answered once");
  a_dbg_secure: assert property (dbgIn.valid && dbgIn.target == ecs_pkg::SEC_S &&
    !(dbgIn.agent inside {ecs_pkg::SEC_S, ecs_pkg::SEC_ROOT}) |=> dbgDeny)
    else $error("secure facility reached");
  a_dbg_root: assert property (dbgIn.valid && dbgIn.target == ecs_pkg::SEC_ROOT &&
    dbgIn.agent != ecs_pkg::SEC_ROOT |=> dbgDeny)
    else $error("root facility reached");
endmodule

bind ecs_error_unit ecs_checker ecs_checker_i (.mclk, .rst_n, .txnIn, .respOut, .intErrIn,
  .evtOut, .queueEnable, .errRecoveryReq, .failureModeIrq, .dbgIn, .dbgGrant, .dbgDeny);

// File: test/ecs_client_model.sv
// Client device model issuing translated transactions.
// Assumes the bench calls send just after a rising edge, then idle.
`timescale 1ns/1ps
module ecs_client_model (
  input  wire logic        mclk,
  output ecs_pkg::ecs_txn_t txnOut
);
  initial txnOut = '0;
  // A gap drops valid first so a slow client never repeats a request
  task automatic send(input ecs_pkg::ecs_txn_t t, input int gap);
    if (gap > 0)
      txnOut <= '0;
    repeat (gap) @(posedge mclk);
    txnOut <= t;
    @(posedge mclk);
  endtask
  task automatic idle;
    txnOut <= '0;
    @(posedge mclk);
  endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the error containment unit.
// Assumes the checker binds itself; expectations queue up for a watcher.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h", $time, a); end end
module tb;
  logic                 mclk, rst_n, regWr, regRd, rdSeen;
  logic [7:0]           regAddr, seed;
  logic [31:0]          regWrData, regRdData;
  logic                 queueEnable, errRecoveryReq, failureModeIrq, dbgGrant, dbgDeny;
  ecs_pkg::ecs_sec_t    regSec;
  ecs_pkg::ecs_txn_t    txnIn;
  ecs_pkg::ecs_resp_t   respOut;
  ecs_pkg::ecs_qerr_t   qErrIn;
  ecs_pkg::ecs_interr_t intErrIn;
  ecs_pkg::ecs_evt_t    evtOut;
  ecs_pkg::ecs_dbg_t    dbgIn;
  logic [31:0]          rdQ[$];
  ecs_pkg::ecs_resp_t   rsQ[$];
  ecs_pkg::ecs_evt_t    evQ[$];
  logic                 dbQ[$];
  int                   compares, miscompares;

  ecs_error_unit ecs_error_unit_i (.mclk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
    .regSec, .regRdData, .txnIn, .respOut, .qErrIn, .intErrIn, .evtOut, .queueEnable,
    .errRecoveryReq, .failureModeIrq, .dbgIn, .dbgGrant, .dbgDeny);
  ecs_client_model ecs_client_model_i (.mclk, .txnOut(txnIn));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Denial follows the requested facility's security state
  function automatic logic deny(input ecs_pkg::ecs_sec_t a, input ecs_pkg::ecs_sec_t t);
    case (t)
      ecs_pkg::SEC_S: return !(a inside {ecs_pkg::SEC_S, ecs_pkg::SEC_ROOT});
      ecs_pkg::SEC_R: return !(a inside {ecs_pkg::SEC_R, ecs_pkg::SEC_ROOT});
      ecs_pkg::SEC_ROOT: return a != ecs_pkg::SEC_ROOT;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] evcode(input ecs_pkg::ecs_errkind_t k);
    case (k)
      ecs_pkg::ERR_WALK: return ecs_pkg::EVT_WALK_EABT;
      ecs_pkg::ERR_STE: return ecs_pkg::EVT_STE_FETCH;
      ecs_pkg::ERR_CD: return ecs_pkg::EVT_CD_FETCH;
      default: return ecs_pkg::EVT_INT_ABORT;
    endcase
  endfunction

  task automatic rd(input logic [7:0] a, input ecs_pkg::ecs_sec_t s, input logic [31:0] e);
    regAddr <= a;
    regSec <= s;
    regRd <= 1'b1;
    regWr <= 1'b0;
    rdQ.push_back(e);
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input ecs_pkg::ecs_sec_t s, input logic [31:0] d);
    regAddr <= a;
    regSec <= s;
    regWrData <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic clr;
    {regRd, regWr, qErrIn, intErrIn, dbgIn} <= '0;
    ecs_client_model_i.idle();
  endtask
  // Any error or failure mode aborts; an event follows only in normal mode
  task automatic tx(input ecs_pkg::ecs_txn_t t, input logic service_failure_mode, input int gap);
    logic ab;
    ab = t.err != ecs_pkg::ERR_NONE || service_failure_mode;
    rsQ.push_back({1'b1, ab, ab & t.pcie});
    if (!service_failure_mode && ab)
      evQ.push_back({1'b1, t.sec, evcode(t.err)});
    ecs_client_model_i.send(t, gap);
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watcher: oldest expectation is compared whenever a result appears
  always @(posedge mclk)
  begin
    rdSeen <= regRd;
    if (rdSeen === 1'b1) `CHK(regRdData, rdQ.pop_front())
    if (respOut.valid === 1'b1) `CHK(respOut, rsQ.pop_front())
    if (evtOut.valid === 1'b1) `CHK(evtOut, evQ.pop_front())
    if ((dbgGrant | dbgDeny) === 1'b1) `CHK(dbgDeny, dbQ.pop_front())
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("unexpected at %0t: run hung", $time);
    summarize();
  end

  initial
  begin
    {rst_n, regWr, regRd, regAddr, regWrData, qErrIn, intErrIn, dbgIn} = '0;
    regSec = ecs_pkg::SEC_NS;
    seed = 8'h28;
    compares = 0;
    miscompares = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(ecs_pkg::OFF_ROOTCR, ecs_pkg::SEC_NS, 32'h1);
    wr(ecs_pkg::OFF_CTRL, ecs_pkg::SEC_NS, 32'h0);
    rd(ecs_pkg::OFF_CTRL, ecs_pkg::SEC_ROOT, 32'(ecs_pkg::CTRL_RST));
    rd(8'h3c, ecs_pkg::SEC_ROOT, 32'h0);
    clr();
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      tx({1'b1, seed[0], seed[2:1], k[2:0]}, 1'b0, k % 2);
    end
    clr();
    for (int k = 0; k < 4; k++)
    begin
      qErrIn <= {1'b1, k[1:0], ecs_pkg::SEC_NS};
      @(posedge mclk);
    end
    qErrIn <= {1'b1, ecs_pkg::Q_CMD, ecs_pkg::SEC_R};
    @(posedge mclk);
    clr();
    rd(ecs_pkg::OFF_GERR_NS, ecs_pkg::SEC_NS, 32'h20d);
    rd(ecs_pkg::OFF_CONS_NS, ecs_pkg::SEC_NS, 32'(ecs_pkg::CMD_ABORT_CODE) << 24);
    rd(ecs_pkg::OFF_DPT_FAR, ecs_pkg::SEC_NS, 32'(ecs_pkg::PERMISSION_TABLE_ABORT_CODE_CODE));
    rd(ecs_pkg::OFF_GERR_R, ecs_pkg::SEC_NS, 32'h0);
    rd(ecs_pkg::OFF_GERR_R, ecs_pkg::SEC_R, 32'h1);
    wr(ecs_pkg::OFF_GERR_NS, ecs_pkg::SEC_NS, 32'hffffffff);
    rd(ecs_pkg::OFF_GERR_NS, ecs_pkg::SEC_NS, 32'h0);
    // Read strobe is one cycle; drop it before the debug burst
    regRd <= 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      seed = lfsr(seed);
      dbgIn <= {1'b1, seed[0], seed[2:1], seed[4:3]};
      dbQ.push_back(deny(ecs_pkg::ecs_sec_t'(seed[2:1]), ecs_pkg::ecs_sec_t'(seed[4:3])));
      @(posedge mclk);
    end
    clr();
    intErrIn <= 2'b11;
    @(posedge mclk);
    clr();
    rd(ecs_pkg::OFF_STATUS, ecs_pkg::SEC_NS, 32'h8);
    regRd <= 1'b0;
    intErrIn <= 2'b10;
    @(posedge mclk);
    qErrIn <= {1'b1, ecs_pkg::Q_PRIQ, ecs_pkg::SEC_NS};
    intErrIn <= 2'b00;
    @(posedge mclk);
    clr();
    tx({1'b1, 1'b1, ecs_pkg::SEC_NS, ecs_pkg::ERR_NONE}, 1'b1, 0);
    clr();
    wr(ecs_pkg::OFF_STATUS, ecs_pkg::SEC_ROOT, 32'hffffffff);
    rd(ecs_pkg::OFF_STATUS, ecs_pkg::SEC_NS, 32'h3);
    rd(ecs_pkg::OFF_GERR_NS, ecs_pkg::SEC_NS, 32'h100);
    rd(ecs_pkg::OFF_GERR_S, ecs_pkg::SEC_S, 32'h100);
    clr();
    `CHK(failureModeIrq, 1'b1)
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(failureModeIrq, 1'b0)
    rd(ecs_pkg::OFF_STATUS, ecs_pkg::SEC_NS, 32'h0);
    clr();
    repeat (2) @(posedge mclk);
    `CHK(rdQ.size() + rsQ.size() + evQ.size() + dbQ.size(), 0)
    summarize();
  end
endmodule
